// ---- ebpm_pkg.sv ----
// package with register map, field positions and carriers for the bus pin mux
package ebpm_pkg;
	localparam logic [31:0] EBPM_OFS_MODE   = 32'h0000_0000; // bus mode control
	localparam logic [31:0] EBPM_OFS_UPPER  = 32'h0000_0004; // upper address output control
	localparam logic [31:0] EBPM_OFS_STATUS = 32'h0000_0008; // pin function status
	localparam logic [31:0] EBPM_OFS_PERIPH = 32'h0000_000c; // peripheral route enables
	localparam int EBPM_MODE_EXT  = 0; // external bus mode
	localparam int EBPM_MODE_MUX  = 1; // 1 multiplexed, 0 non-multiplexed
	localparam int EBPM_MODE_W16  = 2; // bus width 16 bit
	localparam int EBPM_MODE_WSTB  = 3; // write_strobe_pin_enable
	localparam int EBPM_MODE_HOLD  = 4; // hold_pins_enable
	localparam int EBPM_MODE_READY = 5; // ready_pin_enable
	localparam int EBPM_MODE_CKE  = 6; // clock output enable
	localparam logic [6:0] EBPM_MODE_RST  = 7'h00;
	localparam logic [3:0] EBPM_UPPER_RST = 4'h0;
	localparam logic [7:0] EBPM_PER_RST   = 8'h00;
	localparam int EBPM_PER_PULSE = 0; // pulse outputs on upper address pins
	localparam int EBPM_PER_CMP  = 1; // compare outputs on their pins
	localparam int EBPM_PER_LOWA = 2; // 8 low pins serve analog low group
	localparam int EBPM_PER_HIGA = 3; // next 8 low pins serve analog high group
	localparam logic [1:0] EBPM_RESP_OK     = 2'b00;
	localparam logic [1:0] EBPM_RESP_SLVERR = 2'b10;

	// one pin as core side sees it: output value and enable
	typedef struct packed {
		logic o;
		logic oe;
	} ebpm_pin_t;

	// external bus strobes from the bus controller
	typedef struct packed {
		logic [23:0] addr;
		logic        ale;
		logic        rd;
		logic        wr_lo;
		logic        wr_hi;
		logic        hold_ack;
		logic        mclk;
	} ebpm_bus_t;
endpackage

// ---- ebpm_sync.sv ----
// two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ns
module ebpm_sync #(
	parameter int W = 8
) (
	input  wire logic         clock_in,
	input  wire logic         reset_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;

	// first stage read only by the second
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			meta_ff <= '0;
			q_ff    <= '0;
		end else begin
			meta_ff <= d_in;
			q_ff    <= meta_ff;
		end
	end
	assign q_out = q_ff;
endmodule

// ---- ebpm_axil.sv ----
// axi4-lite slave holding the pin mux control registers
`timescale 1ns/1ns
module ebpm_axil
	import ebpm_pkg::*;
(
	input  wire logic        clock_in,
	input  wire logic        reset_in,
	input  wire logic [31:0] awaddr_in,
	input  wire logic        awvalid_in,
	output logic             awready_out,
	input  wire logic [31:0] wdata_in,
	input  wire logic [3:0]  wstrb_in,
	input  wire logic        wvalid_in,
	output logic             wready_out,
	output logic [1:0]       bresp_out,
	output logic             bvalid_out,
	input  wire logic        bready_in,
	input  wire logic [31:0] araddr_in,
	input  wire logic        arvalid_in,
	output logic             arready_out,
	output logic [31:0]      rdata_out,
	output logic [1:0]       rresp_out,
	output logic             rvalid_out,
	input  wire logic        rready_in,
	input  wire logic [31:0] status_in,
	output logic [6:0]       mode_out,
	output logic [3:0]       upper_out,
	output logic [7:0]       periph_out
);
	logic        awrdy_ff, wrdy_ff, ardy_ff, bv_ff, rv_ff;
	logic [31:0] awa_ff, wd_ff, rd_ff;
	logic [3:0]  ws_ff;
	logic [1:0]  br_ff, rr_ff;
	logic [6:0]  mode_ff;
	logic [3:0]  upper_ff;
	logic [7:0]  per_ff;

	// write decode once address and data are both held
	wire do_wr   = !awrdy_ff && !wrdy_ff && !bv_ff;
	wire hit_m   = awa_ff[31:2] == EBPM_OFS_MODE[31:2];
	wire hit_u   = awa_ff[31:2] == EBPM_OFS_UPPER[31:2];
	wire hit_p   = awa_ff[31:2] == EBPM_OFS_PERIPH[31:2];
	wire hit_s   = awa_ff[31:2] == EBPM_OFS_STATUS[31:2];
	wire wr_ok   = hit_m || hit_u || hit_p || hit_s;
	// read decode
	wire [29:0] ra = araddr_in[31:2];
	wire [31:0] rsel =
		(ra == EBPM_OFS_MODE[31:2])   ? {25'h0, mode_ff} :
		(ra == EBPM_OFS_UPPER[31:2])  ? {28'h0, upper_ff} :
		(ra == EBPM_OFS_PERIPH[31:2]) ? {24'h0, per_ff} :
		(ra == EBPM_OFS_STATUS[31:2]) ? status_in : 32'h0;
	wire r_ok = (ra == EBPM_OFS_MODE[31:2]) || (ra == EBPM_OFS_UPPER[31:2]) ||
		(ra == EBPM_OFS_PERIPH[31:2]) || (ra == EBPM_OFS_STATUS[31:2]);
	wire rd_take = arvalid_in && ardy_ff;

	// write channel handshakes and registers
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			awrdy_ff <= 1'b1;
			wrdy_ff  <= 1'b1;
			bv_ff    <= 1'b0;
			awa_ff   <= 32'h0;
			wd_ff    <= 32'h0;
			ws_ff    <= 4'h0;
			br_ff    <= EBPM_RESP_OK;
			mode_ff  <= EBPM_MODE_RST;
			upper_ff <= EBPM_UPPER_RST;
			per_ff   <= EBPM_PER_RST;
		end else begin
			if (awvalid_in && awrdy_ff) begin
				awrdy_ff <= 1'b0;
				awa_ff   <= awaddr_in;
			end
			if (wvalid_in && wrdy_ff) begin
				wrdy_ff <= 1'b0;
				wd_ff <= wdata_in;
				ws_ff <= wstrb_in;
			end
			if (do_wr) begin
				bv_ff <= 1'b1;
				br_ff <= wr_ok ? EBPM_RESP_OK : EBPM_RESP_SLVERR;
				if (hit_m && ws_ff[0]) mode_ff  <= wd_ff[6:0];
				if (hit_u && ws_ff[0]) upper_ff <= wd_ff[3:0];
				if (hit_p && ws_ff[0]) per_ff   <= wd_ff[7:0];
			end
			if (bv_ff && bready_in) begin
				bv_ff    <= 1'b0;
				awrdy_ff <= 1'b1;
				wrdy_ff  <= 1'b1;
			end
		end
	end

	// read channel: one cycle to answer
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			rv_ff   <= 1'b0;
			ardy_ff <= 1'b1;
			rd_ff   <= 32'h0;
			rr_ff   <= EBPM_RESP_OK;
		end else if (rd_take) begin
			rv_ff   <= 1'b1;
			ardy_ff <= 1'b0;
			rd_ff <= rsel;
			rr_ff <= r_ok ? EBPM_RESP_OK : EBPM_RESP_SLVERR;
		end else if (rv_ff && rready_in) begin
			rv_ff   <= 1'b0;
			ardy_ff <= 1'b1;
		end
	end

	assign awready_out = awrdy_ff;
	assign wready_out  = wrdy_ff;
	assign bvalid_out  = bv_ff;
	assign bresp_out   = br_ff;
	assign arready_out = ardy_ff;
	assign rvalid_out  = rv_ff;
	assign rdata_out   = rd_ff;
	assign rresp_out   = rr_ff;
	assign mode_out    = mode_ff;
	assign upper_out   = upper_ff;
	assign periph_out  = per_ff;
endmodule

// ---- ebpm_top.sv ----
// external bus pin multiplexer: selects port, bus or peripheral role per pin
`timescale 1ns/1ns
module ebpm_top
	import ebpm_pkg::*;
(
	input  wire logic        clock_in,
	input  wire logic        reset_in,
	input  wire logic [31:0] s_awaddr_in,
	input  wire logic        s_awvalid_in,
	output logic             s_awready_out,
	input  wire logic [31:0] s_wdata_in,
	input  wire logic [3:0]  s_wstrb_in,
	input  wire logic        s_wvalid_in,
	output logic             s_wready_out,
	output logic [1:0]       s_bresp_out,
	output logic             s_bvalid_out,
	input  wire logic        s_bready_in,
	input  wire logic [31:0] s_araddr_in,
	input  wire logic        s_arvalid_in,
	output logic             s_arready_out,
	output logic [31:0]      s_rdata_out,
	output logic [1:0]       s_rresp_out,
	output logic             s_rvalid_out,
	input  wire logic        s_rready_in,
	input  wire ebpm_bus_t   bus_in,
	input  wire logic [3:0]  pulse_generator_outputs_in,
	input  wire logic [3:0]  compare_event_outputs_in,
	input  wire logic [37:0] port_o_in,
	input  wire logic [37:0] port_oe_in,
	input  wire logic [37:0] pin_in,
	output logic [37:0]      pin_out,
	output logic [37:0]      pin_oe_out,
	output logic [37:0]      port_read_out,
	output logic             bus_hold_request_out,
	output logic             ready_out,
	output logic             converter_trigger_out,
	output logic             free_timer_clock_out,
	output logic [3:0]       capture_trigger_out,
	output logic [15:0]      analog_enable_out
);
	// pin index map: 0-3 upper address, 4-19 low address, 20-27 strobes,
	// 28 shared trigger/clock, 29-32 capture, 33-36 compare, 37 spare
	localparam int PU  = 0;
	localparam int PL  = 4;
	localparam int PS  = 20;
	localparam int PT  = 28;
	localparam int PC  = 29;
	localparam int PO  = 33;
	localparam int NP  = 38;

	logic [6:0]  mode;
	logic [3:0]  upper;
	logic [7:0]  per;
	logic [NP-1:0] pin_s;
	logic [31:0] status;

	// control registers over axi4-lite
	ebpm_axil u_regs (
		.clock_in    (clock_in),
		.reset_in    (reset_in),
		.awaddr_in   (s_awaddr_in),
		.awvalid_in  (s_awvalid_in),
		.awready_out (s_awready_out),
		.wdata_in    (s_wdata_in),
		.wstrb_in    (s_wstrb_in),
		.wvalid_in   (s_wvalid_in),
		.wready_out  (s_wready_out),
		.bresp_out   (s_bresp_out),
		.bvalid_out  (s_bvalid_out),
		.bready_in   (s_bready_in),
		.araddr_in   (s_araddr_in),
		.arvalid_in  (s_arvalid_in),
		.arready_out (s_arready_out),
		.rdata_out   (s_rdata_out),
		.rresp_out   (s_rresp_out),
		.rvalid_out  (s_rvalid_out),
		.rready_in   (s_rready_in),
		.status_in   (status),
		.mode_out    (mode),
		.upper_out   (upper),
		.periph_out  (per)
	);

	// pin levels cross in through two flops
	ebpm_sync #(.W(NP)) u_sync (
		.clock_in (clock_in),
		.reset_in (reset_in),
		.d_in     (pin_in),
		.q_out    (pin_s)
	);

	// mode decode
	wire ext  = mode[EBPM_MODE_EXT];
	wire mux  = mode[EBPM_MODE_MUX];
	wire w16  = mode[EBPM_MODE_W16];
	wire wstb_en  = ext && mode[EBPM_MODE_WSTB];
	wire hold_en  = ext && mode[EBPM_MODE_HOLD];
	wire ready_en = ext && mode[EBPM_MODE_READY];
	wire cke  = ext && mode[EBPM_MODE_CKE];
	wire lowa = ext && !mux;

	logic [NP-1:0] own_sel; // pin taken by bus or peripheral
	logic [NP-1:0] own_o;
	logic [NP-1:0] own_oe;
	logic [NP-1:0] nxt_o;
	logic [NP-1:0] nxt_oe;
	logic [NP-1:0] nxt_rd;

	// per-pin role for the address and routed peripheral pins
	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_up
			wire adr = ext && !upper[i];
			wire pulse = !adr && per[EBPM_PER_PULSE];
			assign own_sel[PU+i] = adr || pulse;
			assign own_o[PU+i]   = adr ? bus_in.addr[20+i] : pulse_generator_outputs_in[i];
			assign own_oe[PU+i]  = 1'b1;
			assign own_sel[PC+i] = 1'b0; // capture pins stay readable ports
			assign own_o[PC+i]   = 1'b0;
			assign own_oe[PC+i]  = 1'b0;
			assign own_sel[PO+i] = per[EBPM_PER_CMP];
			assign own_o[PO+i]   = compare_event_outputs_in[i];
			assign own_oe[PO+i]  = 1'b1;
		end
		for (i = 0; i < 16; i++) begin : g_lo
			wire an = (i < 8) ? per[EBPM_PER_LOWA] : per[EBPM_PER_HIGA];
			assign own_sel[PL+i] = lowa || an;
			assign own_o[PL+i]   = bus_in.addr[i];
			assign own_oe[PL+i]  = lowa;
		end
	endgenerate

	// strobe pins
	assign own_sel[PS+0] = ext;
	assign own_o[PS+0]   = bus_in.ale;
	assign own_oe[PS+0]  = 1'b1;
	assign own_sel[PS+1] = ext;
	assign own_o[PS+1]   = bus_in.rd;
	assign own_oe[PS+1]  = 1'b1;
	assign own_sel[PS+2] = wstb_en;
	assign own_o[PS+2]   = bus_in.wr_lo;
	assign own_oe[PS+2]  = 1'b1;
	assign own_sel[PS+3] = wstb_en && w16;
	assign own_o[PS+3]   = bus_in.wr_hi;
	assign own_oe[PS+3]  = 1'b1;
	assign own_sel[PS+4] = hold_en; // hold request input
	assign own_o[PS+4]   = 1'b0;
	assign own_oe[PS+4]  = 1'b0;
	assign own_sel[PS+5] = hold_en;
	assign own_o[PS+5]   = bus_in.hold_ack;
	assign own_oe[PS+5]  = 1'b1;
	assign own_sel[PS+6] = ready_en;
	assign own_o[PS+6]   = 1'b0;
	assign own_oe[PS+6]  = 1'b0;
	assign own_sel[PS+7] = cke;
	assign own_o[PS+7]   = bus_in.mclk;
	assign own_oe[PS+7]  = 1'b1;
	assign own_sel[PT]   = 1'b0; // shared input, port stays readable
	assign own_o[PT]     = 1'b0;
	assign own_oe[PT]    = 1'b0;
	assign own_sel[NP-1] = 1'b0;
	assign own_o[NP-1]   = 1'b0;
	assign own_oe[NP-1]  = 1'b0;

	// owned pins ignore the port driver and read back zero
	assign nxt_o  = (own_sel & own_o) | (~own_sel & port_o_in);
	assign nxt_oe = (own_sel & own_oe) | (~own_sel & port_oe_in);
	assign nxt_rd = ~own_sel & pin_s;

	assign status = {25'h0, ready_en, hold_en, wstb_en && w16, wstb_en, cke, ext, lowa};

	// registered pin drive and routed inputs
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			pin_out               <= '0;
			pin_oe_out            <= '0;
			port_read_out         <= '0;
			bus_hold_request_out  <= 1'b0;
			ready_out             <= 1'b1;
			converter_trigger_out <= 1'b0;
			free_timer_clock_out  <= 1'b0;
			capture_trigger_out   <= 4'h0;
			analog_enable_out     <= 16'h0;
		end else begin
			pin_out               <= nxt_o;
			pin_oe_out            <= nxt_oe;
			port_read_out         <= nxt_rd;
			bus_hold_request_out  <= hold_en && pin_s[PS+4];
			ready_out             <= ready_en ? pin_s[PS+6] : 1'b1;
			converter_trigger_out <= pin_s[PT];
			free_timer_clock_out  <= pin_s[PT];
			capture_trigger_out   <= pin_s[PC +: 4];
			analog_enable_out     <= {{8{per[EBPM_PER_HIGA]}}, {8{per[EBPM_PER_LOWA]}}};
		end
	end
endmodule

// ---- ebpm_asserts.sv ----
// concurrent checks on the bus pin mux top ports
`timescale 1ns/1ns
module ebpm_asserts (
	input  wire logic        clock_in,
	input  wire logic        reset_in,
	input  wire logic        s_awready_out,
	input  wire logic        s_wready_out,
	input  wire logic [1:0]  s_bresp_out,
	input  wire logic        s_bvalid_out,
	input  wire logic        s_bready_in,
	input  wire logic        s_arvalid_in,
	input  wire logic        s_arready_out,
	input  wire logic [31:0] s_rdata_out,
	input  wire logic        s_rvalid_out,
	input  wire logic        s_rready_in,
	input  wire logic [37:0] pin_oe_out,
	input  wire logic [37:0] port_read_out,
	input  wire logic        bus_hold_request_out,
	input  wire logic        ready_out,
	input  wire logic        converter_trigger_out,
	input  wire logic        free_timer_clock_out
);
	// reset returns every pin to an undriven port
	chk_reset_idle: assert property (@(posedge clock_in)
		reset_in |=> pin_oe_out == 38'h0 && ready_out) else $error("pins driven after reset");
	// register bus answers, holds and refuses new requests while busy
	chk_read_answer: assert property (@(posedge clock_in) disable iff (reset_in)
		s_arvalid_in && s_arready_out |=> s_rvalid_out) else $error("read answer late");
	chk_read_hold: assert property (@(posedge clock_in) disable iff (reset_in)
		s_rvalid_out && !s_rready_in |=> s_rvalid_out && $stable(s_rdata_out))
		else $error("read data dropped");
	chk_write_hold: assert property (@(posedge clock_in) disable iff (reset_in)
		s_bvalid_out && !s_bready_in |=> s_bvalid_out && $stable(s_bresp_out))
		else $error("write response dropped");
	chk_read_refuse: assert property (@(posedge clock_in) disable iff (reset_in)
		s_rvalid_out |-> !s_arready_out) else $error("read taken while busy");
	chk_write_refuse: assert property (@(posedge clock_in) disable iff (reset_in)
		s_bvalid_out |-> !s_awready_out && !s_wready_out) else $error("write taken while busy");
	// shared and owned pins
	chk_trigger_pair: assert property (@(posedge clock_in) disable iff (reset_in)
		converter_trigger_out == free_timer_clock_out) else $error("shared pin split");
	chk_hold_owned: assert property (@(posedge clock_in) disable iff (reset_in)
		bus_hold_request_out |-> port_read_out[24] == 1'b0) else $error("hold pin read as port");
	chk_ready_owned: assert property (@(posedge clock_in) disable iff (reset_in)
		!ready_out |-> port_read_out[26] == 1'b0) else $error("ready pin read as port");
endmodule

bind ebpm_top ebpm_asserts u_chk (.clock_in, .reset_in, .s_awready_out, .s_wready_out,
	.s_bresp_out, .s_bvalid_out, .s_bready_in, .s_arvalid_in, .s_arready_out, .s_rdata_out,
	.s_rvalid_out, .s_rready_in, .pin_oe_out, .port_read_out, .bus_hold_request_out,
	.ready_out, .converter_trigger_out, .free_timer_clock_out);

// ---- ebpm_ext_dev.sv ----
// far-side bus device model driving the pin levels
`timescale 1ns/1ns
module ebpm_ext_dev (
	input  wire logic        clock_in,
	input  wire logic [37:0] pin_out_in,
	input  wire logic [37:0] pin_oe_in,
	input  wire logic [37:0] drive_in,
	input  wire logic [37:0] drive_en_in,
	output logic      [37:0] pin_in_out
);
	logic [37:0] last_ff = 38'h0;
	// remember the level each line last carried while the chip drove it
	always @(posedge clock_in) begin
		for (int k = 0; k < 38; k++) begin
			if (pin_oe_in[k] === 1'b1) last_ff[k] <= pin_out_in[k];
		end
	end
	// chip driver wins, then the device; a released line shows the inverse of its last level
	assign pin_in_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & drive_en_in & drive_in)
		| (~pin_oe_in & ~drive_en_in & ~last_ff);
endmodule

// ---- external_bus_pin_mux_tb.sv ----
// self-checking bench for the bus pin mux
`timescale 1ns/1ns
module external_bus_pin_mux_tb
	import ebpm_pkg::*;
;
	logic        clock_in = 1'b0;
	logic        reset_in = 1'b1;
	logic [31:0] s_awaddr_in = 32'h0, s_wdata_in = 32'h0, s_araddr_in = 32'h0;
	logic [3:0]  s_wstrb_in = 4'hf;
	logic        s_awvalid_in = 1'b0, s_wvalid_in = 1'b0, s_bready_in = 1'b0;
	logic        s_arvalid_in = 1'b0, s_rready_in = 1'b0;
	logic        s_awready_out, s_wready_out, s_bvalid_out, s_arready_out, s_rvalid_out;
	logic [1:0]  s_bresp_out, s_rresp_out;
	logic [31:0] s_rdata_out;
	ebpm_bus_t   bus_in = {24'h9b7e61, 6'h0d};
	logic [3:0]  pulse_generator_outputs_in = 4'h6, compare_event_outputs_in = 4'hf;
	// port drivers; input-only lines stay undriven as software must keep them
	logic [37:0] port_o_in = 38'h2a_c33c_5aa5, port_oe_in = 38'h3e_0fff_ffff;
	logic [37:0] drive_in = 38'h1_5100_0000, drive_en_in = 38'h1_f500_0000;
	logic [37:0] pin_in, pin_out, pin_oe_out, port_read_out;
	logic        bus_hold_request_out, ready_out, converter_trigger_out, free_timer_clock_out;
	logic [3:0]  capture_trigger_out;
	logic [15:0] analog_enable_out;
	int          err_total = 0, samples_checked = 0, cyc = 0;

	ebpm_top dut (.clock_in, .reset_in, .s_awaddr_in, .s_awvalid_in, .s_awready_out,
		.s_wdata_in, .s_wstrb_in, .s_wvalid_in, .s_wready_out, .s_bresp_out, .s_bvalid_out,
		.s_bready_in, .s_araddr_in, .s_arvalid_in, .s_arready_out, .s_rdata_out, .s_rresp_out,
		.s_rvalid_out, .s_rready_in, .bus_in, .pulse_generator_outputs_in,
		.compare_event_outputs_in, .port_o_in, .port_oe_in, .pin_in, .pin_out, .pin_oe_out,
		.port_read_out, .bus_hold_request_out, .ready_out, .converter_trigger_out,
		.free_timer_clock_out, .capture_trigger_out, .analog_enable_out);
	ebpm_ext_dev dev (.clock_in, .pin_out_in(pin_out), .pin_oe_in(pin_oe_out), .drive_in,
		.drive_en_in, .pin_in_out(pin_in));

	// clock and hang guard
	initial forever #4 clock_in = ~clock_in;
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			end_of_test;
		end
	end

	task automatic end_of_test;
		if (err_total == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [75:0] got, input logic [75:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
			err_total++;
		end
	endtask

	// write: address and data offered together, response taken in the first cycle it is valid
	task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aw = 1'b1, w = 1'b1;
		@(posedge clock_in);
		s_awaddr_in <= a;
		s_wdata_in <= d;
		s_awvalid_in <= 1'b1;
		s_wvalid_in <= 1'b1;
		while (aw || w) begin
			@(posedge clock_in);
			if (aw && s_awready_out === 1'b1) begin
				aw = 1'b0;
				s_awvalid_in <= 1'b0;
			end
			if (w && s_wready_out === 1'b1) begin
				w = 1'b0;
				s_wvalid_in <= 1'b0;
			end
		end
		@(posedge clock_in);
		s_bready_in <= 1'b1;
		do @(posedge clock_in); while (s_bvalid_out !== 1'b1);
		s_bready_in <= 1'b0;
		chk(s_bresp_out, r);
	endtask

	// read: address held until taken, data taken late on purpose
	task automatic axr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge clock_in);
		s_araddr_in <= a;
		s_arvalid_in <= 1'b1;
		do @(posedge clock_in); while (s_arready_out !== 1'b1);
		s_arvalid_in <= 1'b0;
		@(posedge clock_in);
		s_rready_in <= 1'b1;
		do @(posedge clock_in); while (s_rvalid_out !== 1'b1);
		s_rready_in <= 1'b0;
		chk({s_rresp_out, s_rdata_out}, {r, d});
	endtask

	// expected pin drive and enable for a given mode, upper control and route set
	function automatic logic [75:0] exp_pins(logic [6:0] m, logic [3:0] u, logic [3:0] p);
		logic [37:0] o, e;
		o = port_o_in;
		e = port_oe_in;
		for (int i = 0; i < 4; i++) begin
			if (m[0] && !u[i]) {o[i], e[i]} = {bus_in.addr[20+i], 1'b1};
			else if (p[0]) {o[i], e[i]} = {pulse_generator_outputs_in[i], 1'b1};
		end
		if (m[0] && !m[1]) begin
			o[19:4] = bus_in.addr[15:0];
			e[19:4] = 16'hffff;
		end else
			e[19:4] = e[19:4] & ~{{8{p[3]}}, {8{p[2]}}};
		if (m[0]) {o[21:20], e[21:20]} = {bus_in.rd, bus_in.ale, 2'h3};
		if (m[0] && m[3]) {o[22], e[22]} = {bus_in.wr_lo, 1'b1};
		if (m[0] && m[3] && m[2]) {o[23], e[23]} = {bus_in.wr_hi, 1'b1};
		if (m[0] && m[4]) {o[25], e[25], e[24]} = {bus_in.hold_ack, 2'h2};
		if (m[0] && m[5]) e[26] = 1'b0;
		if (m[0] && m[6]) {o[27], e[27]} = {bus_in.mclk, 1'b1};
		if (p[1]) {o[36:33], e[36:33]} = {compare_event_outputs_in, 4'hf};
		return {o & e, e};
	endfunction

	// program the three control words, read one back, then check every pin
	task automatic cfg(input logic [6:0] m, input logic [3:0] u, input logic [3:0] p);
		axw(EBPM_OFS_MODE, {25'h0, m}, EBPM_RESP_OK);
		axw(EBPM_OFS_UPPER, {28'h0, u}, EBPM_RESP_OK);
		axw(EBPM_OFS_PERIPH, {28'h0, p}, EBPM_RESP_OK);
		axr(EBPM_OFS_MODE, {25'h0, m}, EBPM_RESP_OK);
		repeat (4) @(posedge clock_in);
		#1 chk({pin_out & pin_oe_out, pin_oe_out}, exp_pins(m, u, p));
	endtask

	// main sequence
	initial begin
		repeat (8) @(posedge clock_in);
		reset_in <= 1'b0;
		axr(EBPM_OFS_MODE, 32'h0, EBPM_RESP_OK);
		axr(EBPM_OFS_UPPER, 32'h0, EBPM_RESP_OK);
		axr(EBPM_OFS_PERIPH, 32'h0, EBPM_RESP_OK);
		axw(32'h0000_0010, 32'h0000_0001, EBPM_RESP_SLVERR);
		axr(32'h0000_0010, 32'h0, EBPM_RESP_SLVERR);
		cfg(7'h00, 4'h0, 4'h0);
		cfg(7'h03, 4'h0, 4'h0);
		cfg(7'h09, 4'h0, 4'h0);
		cfg(7'h7f, 4'h5, 4'h2);
		chk({bus_hold_request_out, ready_out, converter_trigger_out, free_timer_clock_out,
			capture_trigger_out}, 8'hba);
		chk({port_read_out[24], port_read_out[36:33]}, 5'h0);
		cfg(7'h7c, 4'h0, 4'hf);
		chk({bus_hold_request_out, ready_out, analog_enable_out}, 18'h1_ffff);
		chk({port_read_out[37:32], port_read_out[19:4]}, 22'h21_0000);
		// mid-run reset returns every pin to its port and clears the controls
		@(posedge clock_in);
		reset_in <= 1'b1;
		repeat (2) @(posedge clock_in);
		reset_in <= 1'b0;
		axr(EBPM_OFS_MODE, 32'h0, EBPM_RESP_OK);
		#1 chk({pin_out & pin_oe_out, pin_oe_out}, exp_pins(7'h00, 4'h0, 4'h0));
		chk(ready_out, 1'b1);
		end_of_test;
	end
endmodule
